// >>> rtl/nco_top.v
`include "nco_regs.vh"

module nco_top #(
  parameter ACC_W = 20
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire [3:0]  src_clk,
  output reg         osc_pin_a,
  output reg         osc_pin_b,
  output reg         osc_pin_a_oe,
  output reg         osc_pin_b_oe,
  output reg         irq
);

  // ==========================================================
  // registers
  reg  [ACC_W-1:0] phase_accumulator;
  reg  [15:0]      increment_value;
  reg  [7:0]       increment_low;
  reg  [7:0]       increment_high;
  reg  [7:0]       osc_control;
  reg  [7:0]       osc_clock_select;
  reg              osc_pin_select;
  reg              osc_irq_flag;
  reg              osc_irq_enable;
  reg  [3:0]       sync1;
  reg  [3:0]       sync2;
  reg  [3:0]       sync3;
  reg  [7:0]       pulse_cnt;

  wire access   = psel & penable;
  // writes land only at the edge where the master sees pready high
  wire wr       = access & pwrite & pready;
  wire [1:0] ck = osc_clock_select[`NCO_CLK_CK_HI:`NCO_CLK_CK_LO];
  wire [2:0] pws = osc_clock_select[`NCO_CLK_PWS_HI:`NCO_CLK_PWS_LO];
  wire enabled  = osc_control[`NCO_CON_EN];
  // rising edge while second stage is high and third stage is still low
  wire src_tick = sync2[ck] & ~sync3[ck];
  wire step     = enabled & src_tick;
  wire [ACC_W:0] sum = {1'b0, phase_accumulator} + {{(ACC_W-15){1'b0}}, increment_value};
  wire overflow = step & sum[ACC_W];
  wire out_state = osc_control[`NCO_CON_OUT];
  // eight bits so that the widest pulse of 2^7 edges does not wrap to zero
  wire [7:0] pulse_len = 8'h01 << pws;

  wire addr_ok = (paddr == `NCO_ADDR_ACCL) | (paddr == `NCO_ADDR_ACCH) |
                 (paddr == `NCO_ADDR_ACCU) | (paddr == `NCO_ADDR_INCL) |
                 (paddr == `NCO_ADDR_INCH) | (paddr == `NCO_ADDR_CON) |
                 (paddr == `NCO_ADDR_CLK)  | (paddr == `NCO_ADDR_APF) |
                 (paddr == `NCO_ADDR_PERIPH_FLAG_REG_TWO) | (paddr == `NCO_ADDR_PERIPH_ENABLE_REG_TWO);

  // ==========================================================
  // source clock synchroniser
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1 <= 4'h0;
      sync2 <= 4'h0;
      sync3 <= 4'h0;
    end else begin
      sync1 <= src_clk;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // ==========================================================
  // increment registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      increment_low   <= `NCO_INCL_RST;
      increment_high  <= `NCO_INCH_RST;
      increment_value <= {`NCO_INCH_RST, `NCO_INCL_RST};
    end else if (wr && paddr == `NCO_ADDR_INCH) begin
      increment_high <= pwdata[7:0];
    end else if (wr && paddr == `NCO_ADDR_INCL) begin
      increment_low   <= pwdata[7:0];
      // buffered value loads as a unit only on the low write
      increment_value <= {increment_high, pwdata[7:0]};
    end
  end

  // ==========================================================
  // accumulator, control and output state
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_accumulator <= {ACC_W{1'b0}};
      osc_control       <= `NCO_BYTE_ZERO;
      osc_clock_select  <= `NCO_BYTE_ZERO;
      osc_pin_select    <= 1'b0;
      osc_irq_enable    <= 1'b0;
      pulse_cnt         <= 8'h00;
    end else begin
      if (wr && paddr == `NCO_ADDR_ACCL)
        phase_accumulator[7:0] <= pwdata[7:0];
      else if (wr && paddr == `NCO_ADDR_ACCH)
        phase_accumulator[15:8] <= pwdata[7:0];
      else if (wr && paddr == `NCO_ADDR_ACCU)
        phase_accumulator[ACC_W-1:16] <= pwdata[ACC_W-17:0];
      else if (step)
        phase_accumulator <= sum[ACC_W-1:0];
      if (wr && paddr == `NCO_ADDR_CLK)
        osc_clock_select <= pwdata[7:0] & `NCO_CLK_MASK;
      if (wr && paddr == `NCO_ADDR_APF)
        osc_pin_select <= pwdata[`NCO_APF_SEL];
      if (wr && paddr == `NCO_ADDR_PERIPH_ENABLE_REG_TWO)
        osc_irq_enable <= pwdata[`NCO_IRQ_BIT];
      // output bit is hardware-owned; software writes to it are dropped
      if (wr && paddr == `NCO_ADDR_CON)
        osc_control <= {pwdata[7:6], out_state, pwdata[4:0]} & `NCO_CON_MASK;
      if (!enabled) begin
        osc_control[`NCO_CON_OUT] <= 1'b0;
        pulse_cnt <= 8'h00;
      end else if (osc_control[`NCO_CON_PFM]) begin
        // pulse mode: high for 2^pws source clocks after overflow
        if (overflow) begin
          osc_control[`NCO_CON_OUT] <= 1'b1;
          pulse_cnt <= pulse_len;
        end else if (src_tick && pulse_cnt != 8'h00) begin
          pulse_cnt <= pulse_cnt - 8'h01;
          if (pulse_cnt == 8'h01)
            osc_control[`NCO_CON_OUT] <= 1'b0;
        end
      end else if (overflow) begin
        osc_control[`NCO_CON_OUT] <= ~out_state;
      end
    end
  end

  // ==========================================================
  // interrupt flag: set wins over write-one-to-clear
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      osc_irq_flag <= 1'b0;
    else if (overflow)
      osc_irq_flag <= 1'b1;
    else if (wr && paddr == `NCO_ADDR_PERIPH_FLAG_REG_TWO && pwdata[`NCO_IRQ_BIT])
      osc_irq_flag <= 1'b0;
  end

  // ==========================================================
  // pins and interrupt output
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_pin_a    <= 1'b0;
      osc_pin_b    <= 1'b0;
      osc_pin_a_oe <= 1'b0;
      osc_pin_b_oe <= 1'b0;
      irq          <= 1'b0;
    end else begin
      osc_pin_a    <= out_state ^ osc_control[`NCO_CON_POL];
      osc_pin_b    <= out_state ^ osc_control[`NCO_CON_POL];
      osc_pin_a_oe <= osc_control[`NCO_CON_OE] & ~osc_pin_select;
      osc_pin_b_oe <= osc_control[`NCO_CON_OE] & osc_pin_select;
      irq          <= osc_irq_flag & osc_irq_enable;
    end
  end

  // ==========================================================
  // apb slave: one wait state, so pready rises in the access phase's 2nd cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= access & ~pready;
      pslverr <= access & ~pready & ~addr_ok;
      prdata  <= 32'h00000000;
      if (access && !pready && !pwrite) begin
        case (paddr)
          `NCO_ADDR_ACCL: prdata[7:0] <= phase_accumulator[7:0];
          `NCO_ADDR_ACCH: prdata[7:0] <= phase_accumulator[15:8];
          `NCO_ADDR_ACCU: prdata[ACC_W-17:0] <= phase_accumulator[ACC_W-1:16];
          `NCO_ADDR_INCL: prdata[7:0] <= increment_low;
          `NCO_ADDR_INCH: prdata[7:0] <= increment_high;
          `NCO_ADDR_CON:  prdata[7:0] <= osc_control;
          `NCO_ADDR_CLK:  prdata[7:0] <= osc_clock_select;
          `NCO_ADDR_APF:  prdata[`NCO_APF_SEL] <= osc_pin_select;
          `NCO_ADDR_PERIPH_FLAG_REG_TWO: prdata[`NCO_IRQ_BIT] <= osc_irq_flag;
          `NCO_ADDR_PERIPH_ENABLE_REG_TWO: prdata[`NCO_IRQ_BIT] <= osc_irq_enable;
          default:        prdata <= 32'h00000000;
        endcase
      end
    end
  end

endmodule

// >>> rtl/nco_regs.vh
`ifndef NCO_REGS_VH
`define NCO_REGS_VH
// ==========================================================
// register byte addresses
`define NCO_ADDR_ACCL     12'h000
`define NCO_ADDR_ACCH     12'h004
`define NCO_ADDR_ACCU     12'h008
`define NCO_ADDR_INCL     12'h00C
`define NCO_ADDR_INCH     12'h010
`define NCO_ADDR_CON      12'h014
`define NCO_ADDR_CLK      12'h018
`define NCO_ADDR_APF      12'h01C
`define NCO_ADDR_PERIPH_FLAG_REG_TWO     12'h020
`define NCO_ADDR_PERIPH_ENABLE_REG_TWO     12'h024
// ==========================================================
// fields
`define NCO_CON_EN        7
`define NCO_CON_OE        6
`define NCO_CON_OUT       5
`define NCO_CON_POL       4
`define NCO_CON_PFM       0
`define NCO_IRQ_BIT       2
`define NCO_APF_SEL       0
`define NCO_CLK_PWS_HI    7
`define NCO_CLK_PWS_LO    5
`define NCO_CLK_CK_HI     1
`define NCO_CLK_CK_LO     0
`define NCO_CON_MASK      8'hF1
`define NCO_CLK_MASK      8'hE3
// ==========================================================
// reset values
`define NCO_INCL_RST      8'h01
`define NCO_INCH_RST      8'h00
`define NCO_BYTE_ZERO     8'h00
`endif

// >>> sim/nco_top_properties.sv
`include "nco_regs.vh"
// ==========================================
// register read shapes and pin steering
module nco_top_props (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        osc_pin_a,
  input wire logic        osc_pin_b,
  input wire logic        osc_pin_a_oe,
  input wire logic        osc_pin_b_oe
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire rd = pready && !pwrite;
  property p_incl; rd && paddr == `NCO_ADDR_INCL |-> prdata[31:8] == 0; endproperty
  a_incl: assert property (p_incl) else $error("wide low increment read");
  property p_inch; rd && paddr == `NCO_ADDR_INCH |-> prdata[31:8] == 0; endproperty
  a_inch: assert property (p_inch) else $error("wide high increment read");
  property p_con; rd && paddr == `NCO_ADDR_CON |-> (prdata & ~32'hF1) == 0; endproperty
  a_con: assert property (p_con) else $error("control read has unused bits");
  property p_pins; osc_pin_a == osc_pin_b; endproperty
  a_pins: assert property (p_pins) else $error("pins differ");
  property p_flag; rd && paddr == `NCO_ADDR_PERIPH_FLAG_REG_TWO |-> (prdata & ~32'h4) == 0; endproperty
  a_flag: assert property (p_flag) else $error("flag read has stray bits");
  property p_oe; !(osc_pin_a_oe && osc_pin_b_oe); endproperty
  a_oe: assert property (p_oe) else $error("both pins enabled");
  property p_accu; rd && paddr == `NCO_ADDR_ACCU |-> prdata[31:4] == 0; endproperty
  a_accu: assert property (p_accu) else $error("upper accumulator too wide");
  c_flag: cover property (rd && paddr == `NCO_ADDR_PERIPH_FLAG_REG_TWO && prdata[2]);
  c_pinb: cover property ($rose(osc_pin_b_oe));
  c_err: cover property (pready && pslverr);
endmodule
bind nco_top nco_top_props i_props (.pclk, .presetn, .pwrite, .paddr, .prdata, .pready, .pslverr,
  .osc_pin_a, .osc_pin_b, .osc_pin_a_oe, .osc_pin_b_oe);

// >>> sim/test_numeric_osc_registers.sv
`include "nco_regs.vh"
module test_numeric_osc_registers;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, irq;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rdv;
  logic [3:0] src_clk = 0;
  logic a, b, a_oe, b_oe, err;
  int fail_count = 0, n_checks = 0, cyc = 0, n, k;
  logic [15:0] inc;
  nco_top i_nco_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .src_clk, .osc_pin_a(a), .osc_pin_b(b), .osc_pin_a_oe(a_oe), .osc_pin_b_oe(b_oe), .irq);
  initial forever #12.5 pclk = ~pclk;
  // ==========================================
  // bus cycle, compare, verdict
  task automatic apb(input logic w, input logic [11:0] ad, input logic [7:0] d);
    @(posedge pclk) begin psel <= 1; penable <= 0; pwrite <= w; paddr <= ad; pwdata <= {24'h0, d}; end
    @(posedge pclk) penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdv = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      fail_count++;
      $display("CHECK FAILED %0t saw %h want %h", $time, s, e);
    end
  endtask
  task automatic complete_run;
    if (fail_count == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // a slow source edge, wide enough for the three-flop sync
  task automatic edges(input int m);
    repeat (m) begin
      @(posedge pclk) src_clk[k] <= 1;
      repeat (4) @(posedge pclk);
      src_clk[k] <= 0;
      repeat (4) @(posedge pclk);
    end
  endtask
  function automatic int steps(input logic [15:0] i);
    return (32'h100000 + i - 1) / i;
  endfunction
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 40000) begin fail_count++; complete_run(); end
  end
  initial begin
    void'($urandom(16));
    repeat (12) @(posedge pclk);
    presetn <= 1;
    apb(0, `NCO_ADDR_INCL, 0); chk(rdv, 32'h01);
    apb(0, `NCO_ADDR_INCH, 0); chk(rdv, 32'h00);
    apb(0, 12'hFFC, 0); chk({rdv, err}, 33'h1);
    inc = $urandom;
    apb(1, `NCO_ADDR_CON, inc[7:0] & 8'h7F); apb(0, `NCO_ADDR_CON, 0); chk(rdv, inc[7:0] & 8'h51);
    apb(1, `NCO_ADDR_CON, 8'h40); apb(1, `NCO_ADDR_APF, 8'h01);
    repeat (2) @(posedge pclk);
    chk({a_oe, b_oe}, 2'b01);
    apb(1, `NCO_ADDR_APF, 8'h00);
    repeat (2) @(posedge pclk);
    chk({a_oe, b_oe}, 2'b10);
    for (k = 0; k < 4; k++) begin
      inc = 16'h4000 | 16'($urandom);
      n = steps(inc);
      apb(1, `NCO_ADDR_CON, 0);
      apb(1, `NCO_ADDR_ACCL, 0); apb(1, `NCO_ADDR_ACCH, 0); apb(1, `NCO_ADDR_ACCU, 0);
      apb(1, `NCO_ADDR_PERIPH_FLAG_REG_TWO, 8'h04);
      apb(1, `NCO_ADDR_PERIPH_ENABLE_REG_TWO, k != 1 ? 8'h04 : 8'h00);
      apb(1, `NCO_ADDR_INCH, inc[15:8]); apb(1, `NCO_ADDR_INCL, inc[7:0]);
      apb(0, `NCO_ADDR_INCH, 0); chk(rdv, inc[15:8]);
      apb(1, `NCO_ADDR_CLK, 8'(k)); apb(1, `NCO_ADDR_CON, 8'h80);
      edges(n - 1);
      apb(0, `NCO_ADDR_PERIPH_FLAG_REG_TWO, 0); chk(rdv, 32'h0);
      edges(1);
      repeat (6) @(posedge pclk);
      apb(0, `NCO_ADDR_PERIPH_FLAG_REG_TWO, 0); chk(rdv, 32'h4);
      chk(irq, k != 1);
      apb(1, `NCO_ADDR_CON, 0); apb(1, `NCO_ADDR_PERIPH_FLAG_REG_TWO, 8'h04);
      apb(0, `NCO_ADDR_PERIPH_FLAG_REG_TWO, 0); chk({rdv, irq}, 33'h0);
    end
    complete_run();
  end
endmodule
